// ===== src/cps_sequencer.sv
// sequencer logic of the cell protection block
`timescale 1ns/10ps
`include "cps_params.svh"

module cps_sequencer #(
    parameter int unsigned SAMPLE_CYC = `CPS_SAMPLE_CYC,
    parameter int unsigned SAMPLE_FAST_CYC = `CPS_SAMPLE_FAST_CYC,
    parameter int unsigned OVC_RETRY_CYC = `CPS_OVC_RETRY_CYC,
    parameter int unsigned OVD_RETRY_CYC = `CPS_OVD_RETRY_CYC,
    parameter int unsigned OC_CYC = `CPS_OC_CYC,
    parameter int unsigned EN_RISE_CYC = `CPS_EN_RISE_CYC,
    parameter int unsigned EN_FALL_CYC = `CPS_EN_FALL_CYC
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire cps_pkg::cps_sense_type sense_i,
    input wire cps_pkg::cps_apb_req_type apb_i,
    output cps_pkg::cps_apb_rsp_type apb_o,
    output cps_pkg::cps_drive_type drive_o
);
    import cps_pkg::*;

    cps_reg_type s_ff;
    cps_reg_type nxt_s;

    logic en_rise;
    logic awake;
    logic tick;
    logic conducting;
    logic oc_now;
    logic setup;
    logic access;
    logic addr_ok;
    logic [31:0] period;
    logic [31:0] status_word;

    function automatic logic done(input logic [31:0] cnt, input int unsigned lim);
        done = (cnt >= (lim - 32'h1));
    endfunction : done

    function automatic logic [2:0] inc3(input logic [2:0] v);
        inc3 = (v == 3'h7) ? v : v + 3'h1;
    endfunction : inc3

    function automatic cps_reg_type clear_history(input cps_reg_type r);
        cps_reg_type t;
        t = r;
        t.smp_cnt = 32'h0;
        t.oc_cnt = 32'h0;
        t.ovc_cnt = 3'h0;
        t.ovd_cnt = 3'h0;
        t.below_cnt = 3'h0;
        t.fast = 1'b0;
        clear_history = t;
    endfunction : clear_history

    assign awake = s_ff.en_flt && !s_ff.force_off;
    assign period = s_ff.fast ? SAMPLE_FAST_CYC : SAMPLE_CYC;
    assign tick = awake && done(s_ff.smp_cnt, period);
    assign conducting = awake && ((s_ff.st == CPS_ON) || (s_ff.st == CPS_OVC_RETRY)
        || (s_ff.st == CPS_OVD_RETRY) || ((s_ff.st == CPS_OVC) && sense_i.load_det));
    assign oc_now = sense_i.oc_chg || sense_i.oc_dis;
    assign setup = apb_i.psel && !apb_i.penable;
    assign access = apb_i.psel && apb_i.penable;
    assign addr_ok = (apb_i.paddr == `CPS_ADDR_CTRL) || (apb_i.paddr == `CPS_ADDR_STATUS);

    always_comb begin
        status_word = 32'h0;
        status_word[`CPS_STAT_GATE] = drive_o.gate_on;
        status_word[`CPS_STAT_SLEEP] = drive_o.sleep;
        status_word[`CPS_STAT_FAST] = s_ff.fast;
        status_word[`CPS_STAT_FULL] = s_ff.ovc_flag;
        status_word[`CPS_STAT_OVC] = (s_ff.st == CPS_OVC);
        status_word[`CPS_STAT_OVD] = (s_ff.st == CPS_OVD);
        status_word[`CPS_STAT_OC] = (s_ff.st == CPS_OC);
        status_word[`CPS_STAT_ENF] = s_ff.en_flt;
        status_word[`CPS_STAT_RETRY] = (s_ff.st == CPS_OVC_RETRY) || (s_ff.st == CPS_OVD_RETRY);
        status_word[`CPS_STAT_FORCE] = s_ff.force_off;
        status_word[`CPS_STAT_OVC_CNT +: 3] = s_ff.ovc_cnt;
        status_word[`CPS_STAT_OVD_CNT +: 3] = s_ff.ovd_cnt;
        status_word[`CPS_STAT_BELOW_CNT +: 3] = s_ff.below_cnt;
    end

    always_comb begin
        nxt_s = s_ff;
        en_rise = 1'b0;

        // enable qualification: level must stand for the full delay
        if (s_ff.en_flt) begin
            if (enable_i) begin
                nxt_s.en_cnt = 32'h0;
            end else if (done(s_ff.en_cnt, EN_FALL_CYC)) begin // [RQ20] [RQ21]
                nxt_s.en_flt = 1'b0;
                nxt_s.en_cnt = 32'h0;
            end else begin
                nxt_s.en_cnt = s_ff.en_cnt + 32'h1;
            end
        end else begin
            if (!enable_i) begin
                nxt_s.en_cnt = 32'h0;
            end else if (done(s_ff.en_cnt, EN_RISE_CYC)) begin // [RQ20] [RQ21]
                nxt_s.en_flt = 1'b1;
                nxt_s.en_cnt = 32'h0;
                en_rise = 1'b1;
            end else begin
                nxt_s.en_cnt = s_ff.en_cnt + 32'h1;
            end
        end

        // sample timer, held at zero while asleep or forced off
        if (!awake) begin
            nxt_s.smp_cnt = 32'h0; // [RQ18]
        end else if (tick) begin
            nxt_s.smp_cnt = 32'h0; // [RQ1]
        end else begin
            nxt_s.smp_cnt = s_ff.smp_cnt + 32'h1;
        end

        // rate selection and indicator follow each sample
        if (tick) begin
            if (sense_i.over_max) begin
                nxt_s.fast = 1'b1; // [RQ1] [RQ19]
                nxt_s.below_cnt = 3'h0;
            end else begin
                nxt_s.below_cnt = inc3(s_ff.below_cnt);
                if (inc3(s_ff.below_cnt) >= `CPS_N_BELOW) begin
                    nxt_s.fast = 1'b0; // [RQ19]
                end
                nxt_s.ovc_flag = 1'b0; // [RQ7] [RQ8]
            end
        end

        // over-current filter while current can flow
        if (conducting && oc_now) begin
            nxt_s.oc_cnt = s_ff.oc_cnt + 32'h1;
        end else begin
            nxt_s.oc_cnt = 32'h0;
        end

        unique case (s_ff.st)
            CPS_ON: begin
                if (tick) begin
                    if (sense_i.over_max) begin
                        nxt_s.ovc_cnt = inc3(s_ff.ovc_cnt);
                    end else begin
                        nxt_s.ovc_cnt = 3'h0; // [RQ22]
                    end
                    if (sense_i.under_min) begin
                        nxt_s.ovd_cnt = inc3(s_ff.ovd_cnt);
                    end else begin
                        nxt_s.ovd_cnt = 3'h0; // [RQ22]
                    end
                    if (sense_i.over_safe) begin
                        nxt_s.st = CPS_OVC; // [RQ3]
                        nxt_s.ovc_flag = 1'b1; // [RQ6]
                        nxt_s.ovc_cnt = 3'h0;
                    end else if (sense_i.over_max && inc3(s_ff.ovc_cnt) >= `CPS_N_SAMPLE) begin
                        nxt_s.st = CPS_OVC; // [RQ2]
                        nxt_s.ovc_flag = 1'b1; // [RQ6]
                        nxt_s.ovc_cnt = 3'h0;
                    end else if (sense_i.under_min && inc3(s_ff.ovd_cnt) >= `CPS_N_SAMPLE) begin
                        nxt_s.st = CPS_OVD; // [RQ10]
                        nxt_s.ovd_cnt = 3'h0;
                    end
                end
                if (conducting && oc_now && done(s_ff.oc_cnt, OC_CYC)) begin
                    nxt_s.st = CPS_OC; // [RQ13]
                    nxt_s.oc_cnt = 32'h0;
                end
            end
            CPS_OVC: begin
                if (tick && sense_i.over_safe) begin
                    nxt_s.ovc_flag = 1'b1; // [RQ6]
                end
                if (tick && sense_i.below_max_rec) begin
                    nxt_s.st = CPS_ON; // [RQ4]
                end
                if (conducting && oc_now && done(s_ff.oc_cnt, OC_CYC)) begin
                    nxt_s.st = CPS_OC; // [RQ13]
                    nxt_s.oc_cnt = 32'h0;
                end
            end
            CPS_OVD: begin
                if (awake && sense_i.charger_det) begin
                    nxt_s.st = CPS_ON; // [RQ11]
                end
            end
            CPS_OC: begin
                // left only through the enable cycle below
                nxt_s.st = CPS_OC; // [RQ14]
            end
            CPS_OVC_RETRY: begin
                if (awake) begin
                    nxt_s.retry_cnt = s_ff.retry_cnt + 32'h1;
                end
                if (awake && done(s_ff.retry_cnt, OVC_RETRY_CYC)) begin
                    nxt_s.retry_cnt = 32'h0;
                    if (sense_i.over_max) begin
                        nxt_s.st = CPS_OVC; // [RQ5]
                        nxt_s.ovc_flag = 1'b1; // [RQ6]
                    end else begin
                        nxt_s.st = CPS_ON;
                    end
                end
                if (conducting && oc_now && done(s_ff.oc_cnt, OC_CYC)) begin
                    nxt_s.st = CPS_OC; // [RQ13]
                    nxt_s.oc_cnt = 32'h0;
                    nxt_s.retry_cnt = 32'h0;
                end
            end
            CPS_OVD_RETRY: begin
                if (awake) begin
                    nxt_s.retry_cnt = s_ff.retry_cnt + 32'h1;
                end
                if (awake && done(s_ff.retry_cnt, OVD_RETRY_CYC)) begin
                    nxt_s.retry_cnt = 32'h0;
                    nxt_s.st = sense_i.under_min ? CPS_OVD : CPS_ON; // [RQ12]
                end
                if (conducting && oc_now && done(s_ff.oc_cnt, OC_CYC)) begin
                    nxt_s.st = CPS_OC; // [RQ13]
                    nxt_s.oc_cnt = 32'h0;
                    nxt_s.retry_cnt = 32'h0;
                end
            end
        endcase

        // enable recovery: retry the gate and forget all sample history
        if (en_rise) begin
            nxt_s = clear_history(nxt_s); // [RQ16]
            nxt_s.retry_cnt = 32'h0;
            unique case (s_ff.st)
                CPS_OVC, CPS_OVC_RETRY: nxt_s.st = CPS_OVC_RETRY; // [RQ5]
                CPS_OVD, CPS_OVD_RETRY: nxt_s.st = CPS_OVD_RETRY; // [RQ12]
                CPS_OC: nxt_s.st = CPS_ON; // [RQ14]
                CPS_ON: nxt_s.st = CPS_ON;
            endcase
        end

        // register slave: read data latched in setup, write at access
        if (setup) begin
            unique case (apb_i.paddr)
                `CPS_ADDR_CTRL: nxt_s.prdata = {31'h0, s_ff.force_off};
                `CPS_ADDR_STATUS: nxt_s.prdata = status_word;
                default: nxt_s.prdata = 32'h0;
            endcase
        end
        if (access && apb_i.pwrite && apb_i.paddr == `CPS_ADDR_CTRL) begin
            nxt_s.force_off = apb_i.pwdata[`CPS_CTRL_FORCE_OFF];
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_ff <= '{st: CPS_ON, force_off: `CPS_CTRL_RST, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    always_comb begin
        apb_o.prdata = s_ff.prdata;
        apb_o.pready = access;
        apb_o.pslverr = access && !addr_ok;
    end

    always_comb begin
        drive_o.sleep = !s_ff.en_flt; // [RQ18]
        // full gate drive only outside faults and with enable present
        drive_o.gate_on = awake && ((s_ff.st == CPS_ON) || (s_ff.st == CPS_OVC_RETRY)
            || (s_ff.st == CPS_OVD_RETRY)); // [RQ15] [RQ5] [RQ12]
        // overcharged: discharge path only, through biased rectification
        drive_o.active_rect = awake && (s_ff.st == CPS_OVC) && sense_i.load_det; // [RQ9] [RQ4]
        drive_o.cell_bypass = s_ff.ovc_flag; // [RQ6] [RQ7]
        drive_o.full_out = 1'b1;
        drive_o.full_oe = s_ff.ovc_flag; // [RQ8]
        drive_o.fet_bypass = s_ff.en_flt && (s_ff.st == CPS_OC); // [RQ17]
    end

endmodule : cps_sequencer

// ===== src/cps_params.svh
// constants of the cell protection sequencer
// How it works
// RQ1 - sample once per second, faster when overcharged
// RQ2 - four consecutive over-limit samples turn switch off
// RQ3 - one severe-overcharge sample turns off at once
// RQ4 - load or cell below limit restores conduction
// RQ5 - enable rise retries, off again after 1.75 s
// RQ6 - overcharge turn-off drives indicator and cell bypass
// RQ7 - cell below limit releases indicator and bypass
// RQ8 - indicator driven high above limit, else released
// RQ9 - overcharged state conducts discharge, blocks charge
// RQ10 - four 1 Hz under-limit samples turn off
// RQ11 - charger detection ends overdischarge turn-off
// RQ12 - enable rise retries, off again after 4 s
// RQ13 - sustained over-current in either direction turns off
// RQ14 - over-current recovery only by enable low-high
// RQ15 - enable absent holds switch off, present enables
// RQ16 - enable recovery clears sample history and counts
// RQ17 - enable low disconnects the switch bypass resistor
// RQ18 - enable low or absent means sleep, switch off
// RQ19 - fast rate until four samples below limit
// RQ20 - switch follows enable rise 5 ms, fall 3 ms
// RQ21 - short enable pulses are ignored
// RQ22 - a failing sample clears its consecutive counter
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH

`define CPS_CLK_HZ 25000000
`define CPS_CYC_PER_MS (`CPS_CLK_HZ / 1000)

`define CPS_T_SAMPLE_MS 1000
`define CPS_T_SAMPLE_FAST_MS 250
`define CPS_T_OVC_RETRY_MS 1750
`define CPS_T_OVD_RETRY_MS 4000
`define CPS_T_OC_MS 6
`define CPS_T_EN_RISE_MS 5
`define CPS_T_EN_FALL_MS 3

`define CPS_SAMPLE_CYC (`CPS_T_SAMPLE_MS * `CPS_CYC_PER_MS)
`define CPS_SAMPLE_FAST_CYC (`CPS_T_SAMPLE_FAST_MS * `CPS_CYC_PER_MS)
`define CPS_OVC_RETRY_CYC (`CPS_T_OVC_RETRY_MS * `CPS_CYC_PER_MS)
`define CPS_OVD_RETRY_CYC (`CPS_T_OVD_RETRY_MS * `CPS_CYC_PER_MS)
`define CPS_OC_CYC (`CPS_T_OC_MS * `CPS_CYC_PER_MS)
`define CPS_EN_RISE_CYC (`CPS_T_EN_RISE_MS * `CPS_CYC_PER_MS)
`define CPS_EN_FALL_CYC (`CPS_T_EN_FALL_MS * `CPS_CYC_PER_MS)

`define CPS_N_SAMPLE 3'h4
`define CPS_N_BELOW 3'h4

`define CPS_ADDR_CTRL 12'h000
`define CPS_ADDR_STATUS 12'h004
`define CPS_CTRL_FORCE_OFF 0
`define CPS_CTRL_RST 1'h0

`define CPS_STAT_GATE 0
`define CPS_STAT_SLEEP 1
`define CPS_STAT_FAST 2
`define CPS_STAT_FULL 3
`define CPS_STAT_OVC 4
`define CPS_STAT_OVD 5
`define CPS_STAT_OC 6
`define CPS_STAT_ENF 7
`define CPS_STAT_RETRY 8
`define CPS_STAT_FORCE 9
`define CPS_STAT_OVC_CNT 12
`define CPS_STAT_OVD_CNT 16
`define CPS_STAT_BELOW_CNT 20

`endif

// ===== src/cps_pkg.sv
// types of the cell protection sequencer
package cps_pkg;

    typedef enum logic [2:0] {
        CPS_ON,
        CPS_OVC,
        CPS_OVD,
        CPS_OC,
        CPS_OVC_RETRY,
        CPS_OVD_RETRY
    } cps_state_type;

    typedef struct packed {
        logic over_max;
        logic over_safe;
        logic below_max_rec;
        logic under_min;
        logic load_det;
        logic charger_det;
        logic oc_chg;
        logic oc_dis;
    } cps_sense_type;

    typedef struct packed {
        logic gate_on;
        logic active_rect;
        logic cell_bypass;
        logic fet_bypass;
        logic full_out;
        logic full_oe;
        logic sleep;
    } cps_drive_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cps_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cps_apb_rsp_type;

    typedef struct packed {
        cps_state_type st;
        logic en_flt;
        logic [31:0] en_cnt;
        logic [31:0] smp_cnt;
        logic [31:0] retry_cnt;
        logic [31:0] oc_cnt;
        logic [2:0] ovc_cnt;
        logic [2:0] ovd_cnt;
        logic [2:0] below_cnt;
        logic fast;
        logic ovc_flag;
        logic force_off;
        logic [31:0] prdata;
    } cps_reg_type;

endpackage : cps_pkg

// ===== testbench/cps_seq_assertions.sv
// assertions of the cell protection sequencer
`timescale 1ns/10ps
module cps_seq_assertions (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire cps_pkg::cps_sense_type sense_i,
    input wire cps_pkg::cps_apb_req_type apb_i,
    input wire cps_pkg::cps_apb_rsp_type apb_o,
    input wire cps_pkg::cps_drive_type drive_o
);
    import cps_pkg::*;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    sequence en_low;
        !enable_i [*8];
    endsequence
    sequence oc_run;
        (sense_i.oc_chg || sense_i.oc_dis) [*8];
    endsequence
    sleep_off_a: assert property (en_low |-> drive_o.sleep && !drive_o.gate_on)
        else $error("sleep without switch off");
    wake_up_a: assert property (enable_i [*8] |-> !drive_o.sleep)
        else $error("no wake after enable");
    sleep_gate_a: assert property (drive_o.sleep |-> !drive_o.gate_on && !drive_o.active_rect)
        else $error("conducting while asleep");
    fet_drop_a: assert property (en_low |-> !drive_o.fet_bypass)
        else $error("switch bypass kept");
    oc_trip_a: assert property (oc_run |-> !drive_o.gate_on)
        else $error("over-current not tripped");
    oc_latch_a: assert property (drive_o.fet_bypass && enable_i |=> !drive_o.gate_on)
        else $error("over-current left early");
    full_pair_a: assert property ($rose(drive_o.full_oe) |-> drive_o.cell_bypass
        && drive_o.full_out && !drive_o.gate_on)
        else $error("indicator without bypass");
    full_rel_a: assert property ($fell(drive_o.full_oe) |-> !drive_o.cell_bypass
        && !$past(sense_i.over_max))
        else $error("bypass not released");
    rect_load_a: assert property ($rose(drive_o.active_rect) |->
        sense_i.load_det || $past(sense_i.load_det))
        else $error("rectification without load");
    apb_err_a: assert property (apb_i.psel && apb_i.penable
        && !(apb_i.paddr inside {12'h000, 12'h004}) |-> apb_o.pready && apb_o.pslverr)
        else $error("unmapped access accepted");
endmodule : cps_seq_assertions

bind cps_sequencer cps_seq_assertions chk_u (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .enable_i(enable_i),
    .sense_i(sense_i),
    .apb_i(apb_i),
    .apb_o(apb_o),
    .drive_o(drive_o)
);

// ===== testbench/cps_pack_model.sv
// pack terminal model driving the enable pin
`timescale 1ns/10ps
module cps_pack_model (
    input wire logic attach_i,
    output logic enable_o
);
    // detached terminal floats and reads low
    assign enable_o = attach_i;
endmodule : cps_pack_model

// ===== testbench/cell_protection_sequencer_test.sv
// self-checking bench of the cell protection sequencer
`timescale 1ns/10ps
module cell_protection_sequencer_test;
    import cps_pkg::*;
    localparam cps_drive_type G = 7'h40;
    localparam cps_drive_type S = 7'h01;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic att = 1'b0;
    logic en;
    cps_sense_type sns = '0;
    cps_apb_req_type req = '0;
    cps_apb_rsp_type rsp;
    cps_drive_type drv;
    int mismatches = 0;
    int check_count = 0;
    int seed = 32'hbf0b866b;
    int n;
    int k;
    logic [31:0] rd;
    logic [31:0] d;
    logic er;
    always #20 clk = ~clk;
    cps_pack_model pm_u (.attach_i(att), .enable_o(en));
    // shortened timing so every scenario fits the cycle budget
    localparam int unsigned SMP_CYC = 40;
    localparam int unsigned FAST_CYC = 10;
    localparam int unsigned OVC_CYC = 70;
    localparam int unsigned OVD_CYC = 160;
    localparam int unsigned OCF_CYC = 6;
    localparam int unsigned RISE_CYC = 5;
    localparam int unsigned FALL_CYC = 3;
    cps_sequencer #(.SAMPLE_CYC(SMP_CYC), .SAMPLE_FAST_CYC(FAST_CYC),
        .OVC_RETRY_CYC(OVC_CYC), .OVD_RETRY_CYC(OVD_CYC), .OC_CYC(OCF_CYC),
        .EN_RISE_CYC(RISE_CYC), .EN_FALL_CYC(FALL_CYC)) dut_u (
        .core_clk_i(clk), .reset_i(rst), .enable_i(en), .sense_i(sns),
        .apb_i(req), .apb_o(rsp), .drive_o(drv));
    task automatic close_out();
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wait_drv(input cps_drive_type m, input cps_drive_type v, input int lim);
        n = 0;
        while ((drv & m) !== v) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                mismatches++;
                close_out();
            end
        end
    endtask : wait_drv
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int t;
        t = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (t > 20) begin
                mismatches++;
                close_out();
            end
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask : apb
    task automatic set_en(input logic v);
        @(posedge clk);
        att <= v;
        wait_drv(S, v ? 7'h00 : S, 12);
    endtask : set_en
    initial begin
        repeat (16) @(posedge clk);
        chk("reset_drive", drv & 7'h41, 7'h01);
        rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl_reset", rd[0], 1'b0);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped_err", er, 1'b1);
        chk("unmapped_rd", rd, 32'h0);
        set_en(1'b1);
        wait_drv(G, G, 5);
        @(posedge clk);
        sns.under_min <= 1'b1;
        wait_drv(G, 7'h00, 200);
        chk("ovd_delay", n > 118 && n <= 165, 1'b1);
        set_en(1'b0);
        set_en(1'b1);
        wait_drv(G, G, 5);
        apb(1'b0, 12'h004, 32'h0);
        chk("ovd_history", rd[18:16], 3'h0);
        chk("below_history", rd[22:20], 3'h0);
        wait_drv(G, 7'h00, 200);
        chk("ovd_retry", n >= 140 && n <= 170, 1'b1);
        @(posedge clk);
        sns.under_min <= 1'b0;
        sns.charger_det <= 1'b1;
        wait_drv(G, G, 5);
        @(posedge clk);
        sns.charger_det <= 1'b0;
        sns.oc_dis <= 1'b1;
        repeat (8) @(posedge clk);
        sns.oc_dis <= 1'b0;
        wait_drv(7'h48, 7'h08, 5);
        repeat (100) @(negedge clk);
        chk("oc_hold", drv.gate_on, 1'b0);
        set_en(1'b0);
        chk("fet_bypass", drv.fet_bypass, 1'b0);
        set_en(1'b1);
        wait_drv(G, G, 5);
        @(posedge clk);
        sns.over_max <= 1'b1;
        k = 0;
        do begin
            apb(1'b0, 12'h004, 32'h0);
            k++;
        end while (!rd[2] && k < 30);
        chk("ovc_first", rd[14:12], 3'h1);
        wait_drv(G, 7'h00, 60);
        chk("ovc_fast", n >= 20 && n <= 34, 1'b1);
        chk("ovc_full", drv & 7'h16, 7'h16);
        @(posedge clk);
        sns.load_det <= 1'b1;
        repeat (3) @(negedge clk);
        chk("rect", drv & 7'h60, 7'h20);
        @(posedge clk);
        sns.load_det <= 1'b0;
        sns.over_max <= 1'b0;
        sns.below_max_rec <= 1'b1;
        wait_drv(7'h52, 7'h40, 20);
        apb(1'b0, 12'h004, 32'h0);
        chk("ovc_count", rd[14:12], 3'h0);
        // one over-limit sample, then a failing one must zero the run
        sns.over_max <= 1'b1;
        k = 0;
        do begin
            apb(1'b0, 12'h004, 32'h0);
            k++;
        end while (rd[14:12] == 3'h0 && k < 20);
        chk("ovc_partial", rd[14:12], 3'h1);
        sns.over_max <= 1'b0;
        repeat (12) @(posedge clk);
        apb(1'b0, 12'h004, 32'h0);
        chk("ovc_cleared", rd[14:12], 3'h0);
        sns <= '{over_max: 1'b1, over_safe: 1'b1, default: 1'b0};
        wait_drv(G, 7'h00, 45);
        chk("severe", n <= 11, 1'b1);
        @(posedge clk);
        sns.over_safe <= 1'b0;
        set_en(1'b0);
        set_en(1'b1);
        wait_drv(G, G, 5);
        wait_drv(G, 7'h00, 90);
        chk("ovc_retry", n >= 62 && n <= 72, 1'b1);
        @(posedge clk);
        sns <= '{below_max_rec: 1'b1, default: 1'b0};
        wait_drv(G, G, 20);
        // charge-direction over-current, then recovery by an enable cycle
        @(posedge clk);
        sns.oc_chg <= 1'b1;
        repeat (8) @(posedge clk);
        sns.oc_chg <= 1'b0;
        wait_drv(7'h48, 7'h08, 5);
        set_en(1'b0);
        set_en(1'b1);
        wait_drv(G, G, 5);
        repeat (6) begin
            d = $random(seed);
            @(posedge clk);
            att <= 1'b0;
            repeat (1 + d[0]) @(posedge clk);
            att <= 1'b1;
            @(negedge clk);
            chk("glitch", drv.sleep, 1'b0);
            apb(1'b1, 12'h000, d);
            apb(1'b0, 12'h000, 32'h0);
            chk("ctrl_rw", rd[0], d[0]);
            repeat (3) @(negedge clk);
            chk("force", drv.gate_on, !d[0]);
        end
        close_out();
    end
endmodule : cell_protection_sequencer_test
